// file: rtl/nvc_pkg.sv
package nvc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [3:0] IDX_CMD  = 4'h0;
	localparam logic [3:0] IDX_LOCK = 4'h1;
	localparam logic [3:0] IDX_STAT = 4'h2;
	localparam logic [3:0] IDX_IEN  = 4'h3;
	localparam logic [3:0] IDX_IFLG = 4'h4;
	localparam logic [3:0] IDX_DATA = 4'h6;
	localparam logic [3:0] IDX_ADDR = 4'h8;
	localparam logic [3:0] IDX_KEY  = 4'hA;
	localparam int         IDX_LSB  = 2;
	// Field positions
	localparam int FLASH_BUSY_BIT = 0;
	localparam int EE_BUSY_BIT = 1;
	localparam int WR_ERR_BIT = 2;
	localparam int CODE_PROT_BIT = 0;
	localparam int BOOTLK_BIT = 1;
	localparam int EERDY_BIT = 0;
	// Unlock key value is arbitrary
	localparam logic [7:0] UNLOCK_KEY = 8'hA5;
	localparam logic [2:0] KEY_WINDOW = 3'h4;
	// Buffer clear time, CPU cycles, one CPU cycle per clock
	localparam int         CLEAR_CPU_CYCLES = 7;
	localparam logic [2:0] CLEAR_CNT = 3'(CLEAR_CPU_CYCLES - 1);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	typedef enum logic [2:0] {
		CMD_NONE       = 3'h0,
		CMD_STORE      = 3'h1,
		CMD_WIPE       = 3'h2,
		CMD_WIPE_STORE = 3'h3,
		CMD_BUF_CLEAR  = 3'h4,
		CMD_CHIP_CLEAR = 3'h5,
		CMD_EE_CLEAR   = 3'h6,
		CMD_FUSE       = 3'h7
	} nvc_cmd_e;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_CLEAR = 5'h02,
		ST_ERASE = 5'h04,
		ST_WRITE = 5'h08,
		ST_OTHER = 5'h10
	} nvc_state_e;

	// CPU load/store to the arrays
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} nvc_mem_req_s;

	// Level request to the array macro
	typedef struct packed {
		logic        valid;
		nvc_cmd_e    kind;
		logic        eeprom;
		logic        keep_ee;
		logic [15:0] addr;
		logic [15:0] data;
	} nvc_arr_req_s;
endpackage

// file: rtl/nvc_top.sv
// Summary of operation
// - Array reads stall during write or erase
// - One page buffer shared by all sections
// - Stores load buffer, low address bits index
// - Buffer store ANDs new with old
// - Buffer all ones after reset/page op/clear/wake
// - Page store; halts CPU for Flash only
// - EEPROM store touches only written bytes
// - Page wipe needs one written byte
// - Wipe: Flash whole page, EEPROM written bytes
// - Wipe-and-store keeps buffer between phases
// - Buffer clear halts CPU seven cycles
// - Chip clear ignores locks, honours EEPROM preserve
// - EEPROM-wide clear halts CPU while running
// - Fuse programming only from debug port
// - Post-POR lockout rejects writes, shows busy
// - Lockout skipped by fuse settings
// - Reset aborts an ongoing write
// - EEPROM-ready flag drives level interrupt
// - Command field decode 0x0 to 0x7
// - Command write without key is ignored
// - Busy flags follow Flash and EEPROM activity
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module nvc_top #(
	parameter int          PAGE_BYTES      = 64,
	parameter int          POR_LOCK_CYCLES = 1024,
	parameter logic [15:0] EE_BASE         = 16'h1000,
	parameter logic [15:0] EE_SIZE         = 16'h0100
) (
	// Clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 rst_n_in,
	// AXI4-Lite slave
	input  wire logic [5:0]           s_axi_awaddr_in,
	input  wire logic                 s_axi_awvalid_in,
	output logic                      s_axi_awready_out,
	input  wire logic [31:0]          s_axi_wdata_in,
	input  wire logic [3:0]           s_axi_wstrb_in,
	input  wire logic                 s_axi_wvalid_in,
	output logic                      s_axi_wready_out,
	output logic [1:0]                s_axi_bresp_out,
	output logic                      s_axi_bvalid_out,
	input  wire logic                 s_axi_bready_in,
	input  wire logic [5:0]           s_axi_araddr_in,
	input  wire logic                 s_axi_arvalid_in,
	output logic                      s_axi_arready_out,
	output logic [31:0]               s_axi_rdata_out,
	output logic [1:0]                s_axi_rresp_out,
	output logic                      s_axi_rvalid_out,
	input  wire logic                 s_axi_rready_in,
	input  wire logic                 dbg_access_in,
	// CPU array access
	input  wire nvc_pkg::nvc_mem_req_s mem_req_in,
	output logic                      mem_ack_out,
	output logic                      cpu_halt_out,
	output logic                      irq_out,
	// Fuses and system
	input  wire logic                 fuse_ee_preserve_in,
	input  wire logic                 fuse_tout_dis_in,
	input  wire logic                 fuse_rst_dbg_in,
	input  wire logic                 por_flag_in,
	input  wire logic                 wake_in,
	// Array macro
	output nvc_pkg::nvc_arr_req_s     arr_req_out,
	input  wire logic                 arr_done_in,
	input  wire logic [$clog2(PAGE_BYTES)-1:0] pbuf_idx_in,
	output logic [7:0]                pbuf_data_out,
	output logic                      pbuf_mark_out
);
	localparam int PW = $clog2(PAGE_BYTES);
	localparam int LW = $clog2(POR_LOCK_CYCLES + 1);
	localparam logic [LW-1:0] LOCK_LOAD = LW'(POR_LOCK_CYCLES);

	nvc_pkg::nvc_state_e   state_reg, state_next;
	nvc_pkg::nvc_cmd_e     cmd_reg, cmd_next;
	nvc_pkg::nvc_arr_req_s arr_next;
	logic [2:0]            cnt_reg, cnt_next, key_reg, key_next;
	logic [1:0]            lock_reg, lock_next;
	logic                  wrerr_reg, wrerr_next, ien_reg, ien_next;
	logic                  eerdy_reg, eerdy_next, page_ee_reg, page_ee_next;
	logic [15:0]           data_reg, data_next, addr_reg, addr_next, page_reg, page_next;
	logic [PAGE_BYTES-1:0] mark_reg, mark_next;
	logic                  started_reg, started_next;
	logic [LW-1:0]         lcnt_reg, lcnt_next;
	logic                  ack_next, halt_next, irq_next;
	logic                  aw_reg, aw_next, w_reg, w_next, bv_next, rv_next;
	logic [3:0]            awi_reg, awi_next;
	logic [31:0]           wd_reg, wd_next, rd_next;
	logic [3:0]            ws_reg, ws_next;
	logic [1:0]            br_next, rr_next;
	logic [7:0]            pbuf_mem [PAGE_BYTES];
	logic [PW-1:0]         st_idx;
	logic [7:0]            st_val;
	logic                  lockout, idle, store, flash_busy, ee_busy, wr_go, rd_go, cmd_wr;
	logic [31:0]           rd_word;

	// Lockout active until the counter drains after reset release
	assign lockout = !started_reg || (lcnt_reg != '0);
	assign idle = (state_reg == nvc_pkg::ST_IDLE);
	// Busy flags reflect whichever array the current command uses
	assign flash_busy = lockout || (!idle && !(arr_req_out.valid && arr_req_out.eeprom
		&& arr_req_out.kind != nvc_pkg::CMD_CHIP_CLEAR));
	assign ee_busy = lockout || (arr_req_out.valid && (arr_req_out.eeprom
		|| arr_req_out.kind == nvc_pkg::CMD_CHIP_CLEAR));
	// Stores stall while the sequencer is busy and are dropped during lockout, so the merge never races an array op
	assign store = mem_req_in.valid && mem_req_in.write && !mem_ack_out && idle && !lockout;
	assign st_idx = mem_req_in.addr[PW-1:0];
	assign st_val = (mark_reg[st_idx] ? pbuf_mem[st_idx] : nvc_pkg::ERASED_BYTE)
		& mem_req_in.wdata;
	assign wr_go = aw_reg && w_reg && !s_axi_bvalid_out;
	assign rd_go = s_axi_arvalid_in && s_axi_arready_out;
	assign cmd_wr = wr_go && awi_reg == nvc_pkg::IDX_CMD && ws_reg[0];

	// Register read mux
	always_comb
	begin
		rd_word = '0;
		if (s_axi_araddr_in[5:2] == nvc_pkg::IDX_CMD)
			rd_word[2:0] = cmd_reg;
		else if (s_axi_araddr_in[5:2] == nvc_pkg::IDX_LOCK)
			rd_word[1:0] = lock_reg;
		else if (s_axi_araddr_in[5:2] == nvc_pkg::IDX_STAT)
		begin
			rd_word[nvc_pkg::WR_ERR_BIT] = wrerr_reg;
			rd_word[nvc_pkg::EE_BUSY_BIT] = ee_busy;
			rd_word[nvc_pkg::FLASH_BUSY_BIT] = flash_busy;
		end
		else if (s_axi_araddr_in[5:2] == nvc_pkg::IDX_IEN)
			rd_word[nvc_pkg::EERDY_BIT] = ien_reg;
		else if (s_axi_araddr_in[5:2] == nvc_pkg::IDX_IFLG)
			rd_word[nvc_pkg::EERDY_BIT] = eerdy_reg;
		else if (s_axi_araddr_in[5:2] == nvc_pkg::IDX_DATA)
			rd_word[15:0] = data_reg;
		else if (s_axi_araddr_in[5:2] == nvc_pkg::IDX_ADDR)
			rd_word[15:0] = addr_reg;
	end

	// Next state of bus, registers and sequencer
	always_comb
	begin
		aw_next = aw_reg;
		w_next = w_reg;
		awi_next = awi_reg;
		wd_next = wd_reg;
		ws_next = ws_reg;
		bv_next = s_axi_bvalid_out && !s_axi_bready_in;
		br_next = s_axi_bresp_out;
		rv_next = s_axi_rvalid_out && !s_axi_rready_in;
		rd_next = s_axi_rdata_out;
		rr_next = s_axi_rresp_out;
		state_next = state_reg;
		cmd_next = cmd_reg;
		cnt_next = cnt_reg;
		key_next = (key_reg != '0) ? key_reg - 3'h1 : key_reg;
		lock_next = lock_reg;
		wrerr_next = wrerr_reg;
		ien_next = ien_reg;
		eerdy_next = eerdy_reg;
		data_next = data_reg;
		addr_next = addr_reg;
		page_next = page_reg;
		page_ee_next = page_ee_reg;
		mark_next = mark_reg;
		started_next = 1'h1;
		lcnt_next = (lcnt_reg != '0) ? lcnt_reg - LW'(1) : lcnt_reg;
		// Lockout armed once, right after reset release
		if (!started_reg && por_flag_in && fuse_tout_dis_in && !fuse_rst_dbg_in)
			lcnt_next = LOCK_LOAD;
		if (s_axi_awvalid_in && s_axi_awready_out)
		begin
			aw_next = 1'h1;
			awi_next = s_axi_awaddr_in[5:2];
		end
		if (s_axi_wvalid_in && s_axi_wready_out)
		begin
			w_next = 1'h1;
			wd_next = s_axi_wdata_in;
			ws_next = s_axi_wstrb_in;
		end
		if (rd_go)
		begin
			rv_next = 1'h1;
			rd_next = rd_word;
			rr_next = (s_axi_araddr_in[5:2] == nvc_pkg::IDX_CMD || s_axi_araddr_in[5:2] == nvc_pkg::IDX_LOCK
				|| s_axi_araddr_in[5:2] == nvc_pkg::IDX_STAT || s_axi_araddr_in[5:2] == nvc_pkg::IDX_IEN
				|| s_axi_araddr_in[5:2] == nvc_pkg::IDX_IFLG || s_axi_araddr_in[5:2] == nvc_pkg::IDX_DATA
				|| s_axi_araddr_in[5:2] == nvc_pkg::IDX_ADDR || s_axi_araddr_in[5:2] == nvc_pkg::IDX_KEY)
				? nvc_pkg::RESP_OKAY : nvc_pkg::RESP_SLVERR;
		end
		// Buffer store: shared page and section captured on every store
		if (store)
		begin
			mark_next[st_idx] = 1'h1;
			page_next = {mem_req_in.addr[15:PW], PW'(0)};
			page_ee_next = (mem_req_in.addr >= EE_BASE) && (mem_req_in.addr < EE_BASE + EE_SIZE);
		end
		// Register writes, decoded in priority order
		if (wr_go)
		begin
			aw_next = 1'h0;
			w_next = 1'h0;
			bv_next = 1'h1;
			br_next = nvc_pkg::RESP_OKAY;
			if (awi_reg == nvc_pkg::IDX_CMD)
			begin
				// Without a live key the register keeps its value
				if (ws_reg[0] && key_reg != '0 && idle && !lockout)
				begin
					key_next = '0;
					cmd_next = nvc_pkg::nvc_cmd_e'(wd_reg[2:0]);
					case (nvc_pkg::nvc_cmd_e'(wd_reg[2:0]))
						nvc_pkg::CMD_STORE:
							state_next = nvc_pkg::ST_WRITE;
						nvc_pkg::CMD_WIPE, nvc_pkg::CMD_WIPE_STORE:
							if (mark_reg != '0)
								state_next = nvc_pkg::ST_ERASE;
							else
								cmd_next = nvc_pkg::CMD_NONE;
						nvc_pkg::CMD_BUF_CLEAR:
						begin
							state_next = nvc_pkg::ST_CLEAR;
							cnt_next = nvc_pkg::CLEAR_CNT;
						end
						nvc_pkg::CMD_FUSE:
							if (dbg_access_in)
								state_next = nvc_pkg::ST_OTHER;
							else
							begin
								cmd_next = nvc_pkg::CMD_NONE;
								wrerr_next = 1'h1;
							end
						nvc_pkg::CMD_CHIP_CLEAR, nvc_pkg::CMD_EE_CLEAR:
							state_next = nvc_pkg::ST_OTHER;
						default:
							cmd_next = nvc_pkg::CMD_NONE;
					endcase
				end
			end
			else if (awi_reg == nvc_pkg::IDX_LOCK)
			begin
				if (ws_reg[0])
					lock_next = lock_reg | wd_reg[1:0];
			end
			else if (awi_reg == nvc_pkg::IDX_IEN)
			begin
				if (ws_reg[0])
					ien_next = wd_reg[nvc_pkg::EERDY_BIT];
			end
			else if (awi_reg == nvc_pkg::IDX_IFLG)
			begin
				if (ws_reg[0] && wd_reg[nvc_pkg::EERDY_BIT])
					eerdy_next = 1'h0;
			end
			else if (awi_reg == nvc_pkg::IDX_DATA)
			begin
				data_next[7:0] = ws_reg[0] ? wd_reg[7:0] : data_reg[7:0];
				data_next[15:8] = ws_reg[1] ? wd_reg[15:8] : data_reg[15:8];
			end
			else if (awi_reg == nvc_pkg::IDX_ADDR)
			begin
				addr_next[7:0] = ws_reg[0] ? wd_reg[7:0] : addr_reg[7:0];
				addr_next[15:8] = ws_reg[1] ? wd_reg[15:8] : addr_reg[15:8];
			end
			else if (awi_reg == nvc_pkg::IDX_KEY)
			begin
				if (ws_reg[0] && wd_reg[7:0] == nvc_pkg::UNLOCK_KEY)
					key_next = nvc_pkg::KEY_WINDOW;
			end
			else
				br_next = nvc_pkg::RESP_SLVERR;
		end
		// Sequencer progress
		case (state_reg)
			nvc_pkg::ST_CLEAR:
				if (cnt_reg == '0)
				begin
					state_next = nvc_pkg::ST_IDLE;
					mark_next = '0;
					cmd_next = nvc_pkg::CMD_NONE;
				end
				else
					cnt_next = cnt_reg - 3'h1;
			nvc_pkg::ST_ERASE, nvc_pkg::ST_WRITE, nvc_pkg::ST_OTHER:
				if (arr_done_in)
				begin
					// Erase phase of wipe-and-store keeps the buffer
					if (state_reg == nvc_pkg::ST_ERASE && cmd_reg == nvc_pkg::CMD_WIPE_STORE)
						state_next = nvc_pkg::ST_WRITE;
					else
					begin
						state_next = nvc_pkg::ST_IDLE;
						cmd_next = nvc_pkg::CMD_NONE;
						if (state_reg != nvc_pkg::ST_OTHER)
							mark_next = '0;
						if (page_ee_reg || state_reg == nvc_pkg::ST_OTHER)
							eerdy_next = 1'h1;
					end
				end
			default:
				;
		endcase
		if (wake_in && idle)
			mark_next = '0;
		// Array request follows the next state
		arr_next = '0;
		arr_next.valid = (state_next == nvc_pkg::ST_ERASE) || (state_next == nvc_pkg::ST_WRITE)
			|| (state_next == nvc_pkg::ST_OTHER);
		arr_next.kind = (state_next == nvc_pkg::ST_ERASE) ? nvc_pkg::CMD_WIPE
			: (state_next == nvc_pkg::ST_WRITE) ? nvc_pkg::CMD_STORE
			: (state_next == nvc_pkg::ST_OTHER) ? cmd_next : nvc_pkg::CMD_NONE;
		arr_next.eeprom = (state_next == nvc_pkg::ST_OTHER) ? (cmd_next == nvc_pkg::CMD_EE_CLEAR) : page_ee_next;
		arr_next.keep_ee = fuse_ee_preserve_in;
		arr_next.addr = (state_next == nvc_pkg::ST_OTHER) ? addr_next : page_next;
		arr_next.data = data_next;
		// Halt for Flash page ops and every whole-array or clear op
		halt_next = (state_next == nvc_pkg::ST_CLEAR) || (state_next == nvc_pkg::ST_OTHER)
			|| (arr_next.valid && !page_ee_next);
		irq_next = eerdy_next && ien_next;
		// Reads wait while the sequencer is not idle; lockout does not hold them
		ack_next = mem_req_in.valid && !mem_ack_out
			&& (mem_req_in.write ? (idle || lockout) : idle);
	end

	// Control registers; reset drops any array request at once
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= nvc_pkg::ST_IDLE;
			arr_req_out <= '0;
			cmd_reg <= nvc_pkg::CMD_NONE;
			cnt_reg <= '0;
			key_reg <= '0;
			lock_reg <= '0;
			wrerr_reg <= 1'h0;
			ien_reg <= 1'h0;
			eerdy_reg <= 1'h0;
			data_reg <= '0;
			addr_reg <= '0;
			page_reg <= '0;
			page_ee_reg <= 1'h0;
			mark_reg <= '0;
			started_reg <= 1'h0;
			lcnt_reg <= '0;
			mem_ack_out <= 1'h0;
			cpu_halt_out <= 1'h0;
			irq_out <= 1'h0;
			aw_reg <= 1'h0;
			w_reg <= 1'h0;
			awi_reg <= '0;
			wd_reg <= '0;
			ws_reg <= '0;
			s_axi_awready_out <= 1'h0;
			s_axi_wready_out <= 1'h0;
			s_axi_arready_out <= 1'h0;
			s_axi_bvalid_out <= 1'h0;
			s_axi_bresp_out <= nvc_pkg::RESP_OKAY;
			s_axi_rvalid_out <= 1'h0;
			s_axi_rdata_out <= '0;
			s_axi_rresp_out <= nvc_pkg::RESP_OKAY;
		end
		else
		begin
			state_reg <= state_next;
			arr_req_out <= arr_next;
			cmd_reg <= cmd_next;
			cnt_reg <= cnt_next;
			key_reg <= key_next;
			lock_reg <= lock_next;
			wrerr_reg <= wrerr_next;
			ien_reg <= ien_next;
			eerdy_reg <= eerdy_next;
			data_reg <= data_next;
			addr_reg <= addr_next;
			page_reg <= page_next;
			page_ee_reg <= page_ee_next;
			mark_reg <= mark_next;
			started_reg <= started_next;
			lcnt_reg <= lcnt_next;
			mem_ack_out <= ack_next;
			cpu_halt_out <= halt_next;
			irq_out <= irq_next;
			aw_reg <= aw_next;
			w_reg <= w_next;
			awi_reg <= awi_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			s_axi_awready_out <= !aw_next;
			s_axi_wready_out <= !w_next;
			s_axi_arready_out <= !rv_next;
			s_axi_bvalid_out <= bv_next;
			s_axi_bresp_out <= br_next;
			s_axi_rvalid_out <= rv_next;
			s_axi_rdata_out <= rd_next;
			s_axi_rresp_out <= rr_next;
		end
	end

	// Buffer storage; unmarked bytes read as erased, so no reset needed
	always_ff @(posedge mclk_in)
	begin
		if (store)
			pbuf_mem[st_idx] <= st_val;
	end

	// Array-side buffer read; mark selects bytes for EEPROM
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pbuf_data_out <= nvc_pkg::ERASED_BYTE;
			pbuf_mark_out <= 1'h0;
		end
		else
		begin
			pbuf_data_out <= mark_reg[pbuf_idx_in] ? pbuf_mem[pbuf_idx_in] : nvc_pkg::ERASED_BYTE;
			pbuf_mark_out <= mark_reg[pbuf_idx_in];
		end
	end

	a_read_stall: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		mem_req_in.valid && !mem_req_in.write && !idle |=> !mem_ack_out)
		else $error("array read not stalled while busy");
	a_store_marks: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		store |=> mark_reg[$past(st_idx)] && page_reg[15:PW] == $past(mem_req_in.addr[15:PW]))
		else $error("store did not mark buffer");
	a_clear_halt: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		$rose(state_reg == nvc_pkg::ST_CLEAR) |-> cpu_halt_out [*7] ##1 (!cpu_halt_out && mark_reg == '0))
		else $error("buffer clear halt not seven cycles");
	a_wipe_empty: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		cmd_wr && wd_reg[2:0] == nvc_pkg::CMD_WIPE && mark_reg == '0 |=> idle)
		else $error("wipe started with empty buffer");
	a_fuse_cpu: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		cmd_wr && !dbg_access_in |=> !(arr_req_out.valid && arr_req_out.kind == nvc_pkg::CMD_FUSE))
		else $error("cpu started fuse write");
	a_lock_busy: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		lockout |-> flash_busy && ee_busy && !arr_req_out.valid)
		else $error("lockout not showing busy");
	a_done_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == nvc_pkg::ST_WRITE && arr_done_in |=> mark_reg == '0 && idle)
		else $error("buffer not cleared after store");
	a_key_needed: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		cmd_wr && key_reg == '0 |=> cmd_reg == $past(cmd_reg))
		else $error("command taken without key");
	a_flash_halt: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		arr_req_out.valid && arr_req_out.kind == nvc_pkg::CMD_STORE |-> cpu_halt_out == !page_ee_reg)
		else $error("halt wrong for page store");
	a_irq_level: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		eerdy_reg && ien_reg |-> irq_out)
		else $error("interrupt not raised");
	c_wipe_store: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
		state_reg == nvc_pkg::ST_ERASE ##[1:50] state_reg == nvc_pkg::ST_WRITE);
	c_clear: cover property (@(posedge mclk_in) disable iff (!rst_n_in) state_reg == nvc_pkg::ST_CLEAR);
	c_ee_irq: cover property (@(posedge mclk_in) disable iff (!rst_n_in) $rose(irq_out));
endmodule // nvc_top

// file: verif/nvc_array_model.sv
`timescale 1ns/10ps
// Array stand-in: answers every request phase delay_in + 1 cycles after it starts
module nvc_array_model (
	// Clock and reset
	input  wire logic                  mclk_in,
	input  wire logic                  rst_n_in,
	// Request, delay and done pulse
	input  wire nvc_pkg::nvc_arr_req_s req_in,
	input  wire logic [7:0]            delay_in,
	output logic                       done_out
);
	logic [7:0] cnt_reg;

	// Count restarts after each pulse, so a two-phase op gets one answer per phase
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cnt_reg <= 8'h00;
		else if (!req_in.valid || done_out)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= cnt_reg + 8'h01;
	end

	// One-cycle pulse; delays below three could re-fire while valid lingers
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			done_out <= 1'h0;
		else
			done_out <= req_in.valid && !done_out && (cnt_reg == delay_in);
	end
endmodule // nvc_array_model

// file: verif/test_nvm_page_programming_controller.sv
`timescale 1ns/10ps
module test_nvm_page_programming_controller;
	// Bench-driven inputs and observed outputs
	logic                  mclk_in = 1'h0;
	logic                  rst_n_in = 1'h0;
	logic [5:0]            awaddr = 6'h00, araddr = 6'h00, pidx = 6'h00;
	logic [31:0]           wdata = 32'h0, rdata, d;
	logic [3:0]            wstrb = 4'hF;
	logic                  awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic                  dbg = 1'h0, f_pres = 1'h1, f_tout = 1'h1, f_rdbg = 1'h0, por = 1'h1, wake = 1'h0;
	logic                  awready, wready, bvalid, arready, rvalid, mack, halt, irq, done, pmark;
	logic [1:0]            bresp, rresp, r;
	logic [7:0]            pdat, dly = 8'h03;
	nvc_pkg::nvc_mem_req_s mreq = '0;
	nvc_pkg::nvc_arr_req_s areq;
	int                    err_count = 0, comparisons = 0, cyc = 0;

	// 125 MHz clock
	always #4 mclk_in = ~mclk_in;

	// Short lockout keeps the run brief
	nvc_top #(.POR_LOCK_CYCLES(8)) dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.dbg_access_in(dbg), .mem_req_in(mreq), .mem_ack_out(mack), .cpu_halt_out(halt), .irq_out(irq),
		.fuse_ee_preserve_in(f_pres), .fuse_tout_dis_in(f_tout), .fuse_rst_dbg_in(f_rdbg),
		.por_flag_in(por), .wake_in(wake), .arr_req_out(areq), .arr_done_in(done),
		.pbuf_idx_in(pidx), .pbuf_data_out(pdat), .pbuf_mark_out(pmark));
	nvc_array_model model_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(areq), .delay_in(dly),
		.done_out(done));

	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Write: each valid drops when taken, bready rises once both are taken
	task automatic wr(input logic [3:0] i, input logic [31:0] v, input logic [1:0] exp_resp);
		awaddr <= {i, 2'h0};
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		forever
		begin
			@(posedge mclk_in);
			if (bready && bvalid)
				break;
			awvalid <= awvalid && !awready;
			wvalid <= wvalid && !wready;
			bready <= (!awvalid || awready) && (!wvalid || wready);
		end
		bready <= 1'h0;
		check(bresp, exp_resp);
	endtask

	// Read into d and r
	task automatic rd(input logic [3:0] i);
		araddr <= {i, 2'h0};
		arvalid <= 1'h1;
		forever
		begin
			@(posedge mclk_in);
			if (rready && rvalid)
				break;
			arvalid <= arvalid && !arready;
			rready <= !arvalid || arready;
		end
		rready <= 1'h0;
		d = rdata;
		r = rresp;
	endtask

	task automatic rdc(input logic [3:0] i, input logic [31:0] m, input logic [31:0] e);
		rd(i);
		check(d & m, e);
	endtask

	// Idle check, unlock key, then command inside the window
	task automatic cmd(input logic [2:0] c, input logic dv);
		dbg <= dv;
		rdc(nvc_pkg::IDX_STAT, 32'h3, 32'h0);
		wr(nvc_pkg::IDX_KEY, {24'h0, nvc_pkg::UNLOCK_KEY}, nvc_pkg::RESP_OKAY);
		wr(nvc_pkg::IDX_CMD, {29'h0, c}, nvc_pkg::RESP_OKAY);
	endtask

	task automatic waitv(input logic x, input int lim);
		int n;
		n = 0;
		while (areq.valid !== x && n < lim)
		begin
			@(posedge mclk_in);
			n++;
		end
	endtask

	// Fields: valid, kind, eeprom, keep_ee, halt
	task automatic op(input logic [2:0] c, input logic dv, input logic [6:0] m, input logic [6:0] e);
		cmd(c, dv);
		waitv(1'h1, 12);
		check({areq.valid, areq.kind, areq.eeprom, areq.keep_ee, halt} & m, e);
		waitv(1'h0, 400);
	endtask

	task automatic peek(input logic [5:0] i, input logic [8:0] e);
		pidx <= i;
		repeat (2) @(posedge mclk_in);
		check({pmark, pdat}, e);
	endtask

	// CPU array access, held until acknowledged
	task automatic mem(input logic w, input logic [15:0] a, input logic [7:0] v);
		mreq <= '{1'h1, w, a, v};
		do
			@(posedge mclk_in);
		while (mack !== 1'h1);
		mreq.valid <= 1'h0;
		@(posedge mclk_in);
	endtask

	task automatic rst(input logic t, input logic rb);
		rst_n_in <= 1'h0;
		f_tout <= t;
		f_rdbg <= rb;
		por <= t;
		repeat (6) @(posedge mclk_in);
		rst_n_in <= 1'h1;
		repeat (2) @(posedge mclk_in);
	endtask

	task automatic t_lockout();
		rst(1'h1, 1'h0);
		rdc(nvc_pkg::IDX_STAT, 32'h3, 32'h3);
		mem(1'h1, 16'h0001, 8'h00);
		repeat (12) @(posedge mclk_in);
		rdc(nvc_pkg::IDX_STAT, 32'h7, 32'h0);
		peek(6'h01, 9'h0FF);
		rst(1'h0, 1'h0);
		rdc(nvc_pkg::IDX_STAT, 32'h3, 32'h0);
		rst(1'h1, 1'h1);
		rdc(nvc_pkg::IDX_STAT, 32'h3, 32'h0);
	endtask

	task automatic t_merge();
		mem(1'h1, 16'h0005, 8'hF0);
		mem(1'h1, 16'h0005, 8'h3C);
		peek(6'h05, 9'h130);
		peek(6'h06, 9'h0FF);
		wake <= 1'h1;
		@(posedge mclk_in);
		wake <= 1'h0;
		peek(6'h05, 9'h0FF);
	endtask

	task automatic t_clear();
		int n;
		n = 0;
		mem(1'h1, 16'h0009, 8'h00);
		cmd(nvc_pkg::CMD_BUF_CLEAR, 1'h0);
		while (halt !== 1'h1)
			@(posedge mclk_in);
		while (halt === 1'h1)
		begin
			n++;
			@(posedge mclk_in);
		end
		check(n, 7);
		peek(6'h09, 9'h0FF);
	endtask

	task automatic t_flash();
		mem(1'h1, 16'h0005, 8'h12);
		op(nvc_pkg::CMD_STORE, 1'h0, 7'h7D, 7'h49);
		peek(6'h05, 9'h0FF);
		op(nvc_pkg::CMD_WIPE, 1'h0, 7'h40, 7'h00);
	endtask

	// Slow array so the EEPROM op can be observed while it runs
	task automatic t_eeprom();
		dly <= 8'h14;
		mem(1'h1, 16'h1003, 8'h00);
		cmd(nvc_pkg::CMD_WIPE, 1'h0);
		waitv(1'h1, 12);
		check({areq.kind, areq.eeprom, halt}, 5'h0A);
		check(areq.addr, 16'h1000);
		peek(6'h03, 9'h100);
		peek(6'h04, 9'h0FF);
		rdc(nvc_pkg::IDX_STAT, 32'h3, 32'h2);
		mem(1'h0, 16'h1003, 8'h00);
		check(areq.valid, 1'h0);
		rdc(nvc_pkg::IDX_IFLG, 32'h1, 32'h1);
		wr(nvc_pkg::IDX_IEN, 32'h1, nvc_pkg::RESP_OKAY);
		repeat (2) @(posedge mclk_in);
		check(irq, 1'h1);
		wr(nvc_pkg::IDX_IFLG, 32'h1, nvc_pkg::RESP_OKAY);
		repeat (2) @(posedge mclk_in);
		check(irq, 1'h0);
	endtask

	// Buffer filled first, then one erase-then-program command
	task automatic t_ws();
		mem(1'h1, 16'h0007, 8'h5A);
		cmd(nvc_pkg::CMD_WIPE_STORE, 1'h0);
		waitv(1'h1, 12);
		check({areq.kind, areq.eeprom, halt}, 5'h09);
		while (areq.kind !== nvc_pkg::CMD_STORE)
			@(posedge mclk_in);
		peek(6'h07, 9'h15A);
		check(halt, 1'h1);
		waitv(1'h0, 400);
		peek(6'h07, 9'h0FF);
		dly <= 8'h03;
	endtask

	task automatic t_special();
		wr(nvc_pkg::IDX_LOCK, 32'h3, nvc_pkg::RESP_OKAY);
		op(nvc_pkg::CMD_CHIP_CLEAR, 1'h0, 7'h7B, 7'h6B);
		f_pres <= 1'h0;
		op(nvc_pkg::CMD_CHIP_CLEAR, 1'h0, 7'h7B, 7'h69);
		op(nvc_pkg::CMD_EE_CLEAR, 1'h0, 7'h7F, 7'h75);
		op(nvc_pkg::CMD_FUSE, 1'h0, 7'h40, 7'h00);
		rdc(nvc_pkg::IDX_STAT, 32'h4, 32'h4);
		wr(nvc_pkg::IDX_ADDR, 32'h0002, nvc_pkg::RESP_OKAY);
		wr(nvc_pkg::IDX_DATA, 32'h00C3, nvc_pkg::RESP_OKAY);
		cmd(nvc_pkg::CMD_FUSE, 1'h1);
		waitv(1'h1, 12);
		check({areq.valid, areq.kind, halt}, 5'h1F);
		check({areq.addr, areq.data}, 32'h000200C3);
		waitv(1'h0, 400);
		op(nvc_pkg::CMD_NONE, 1'h0, 7'h40, 7'h00);
		mem(1'h1, 16'h0005, 8'h00);
		wr(nvc_pkg::IDX_CMD, 32'h1, nvc_pkg::RESP_OKAY);
		repeat (4) @(posedge mclk_in);
		check(areq.valid, 1'h0);
		rdc(nvc_pkg::IDX_CMD, 32'h7, 32'h0);
		wr(4'h5, 32'h0, nvc_pkg::RESP_SLVERR);
		rd(4'h5);
		check(r, nvc_pkg::RESP_SLVERR);
	endtask

	task automatic t_abort();
		dly <= 8'h14;
		mem(1'h1, 16'h1000, 8'h00);
		cmd(nvc_pkg::CMD_STORE, 1'h0);
		waitv(1'h1, 12);
		rst(1'h1, 1'h1);
		check(areq.valid, 1'h0);
		peek(6'h00, 9'h0FF);
	endtask

	task final_report();
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard, far above the several hundred cycles the run needs
	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			final_report();
		end
	end

	// Main sequence
	initial
	begin
		t_lockout();
		t_merge();
		t_clear();
		t_flash();
		t_eeprom();
		t_ws();
		t_special();
		t_abort();
		final_report();
	end
endmodule // test_nvm_page_programming_controller
